// ===== include/nsi_regs.svh
// Constants of the network status indicator block
`ifndef NSI_REGS_SVH
`define NSI_REGS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define NSI_CLK_HZ 50000000
`define NSI_STRETCH_MS 50
`define NSI_STRETCH_CYCLES ((`NSI_CLK_HZ / 1000) * `NSI_STRETCH_MS)
`define NSI_OSC_HZ 20000000
// Toggle ratio 2*osc/clk reduced to 4/5
`define NSI_OSC_STEP 4'h4
`define NSI_OSC_MOD 4'h5

// ****************************************************************
// Register offsets
// ****************************************************************
`define NSI_OFS_CTRL 32'h0000_0000
`define NSI_OFS_STATUS 32'h0000_0004
`define NSI_OFS_INT_STATUS 32'h0000_0008
`define NSI_OFS_INT_MASK 32'h0000_000c

// ****************************************************************
// Field positions
// ****************************************************************
`define NSI_CTRL_LAMP_TEST 0
`define NSI_CTRL_LED_OFF 1
`define NSI_ST_TX_IND 0
`define NSI_ST_COL_IND 1
`define NSI_ST_LINK_OUT 2
`define NSI_ST_LINK_IN 3
`define NSI_ST_LINK_OK 4
`define NSI_ST_PATH_AUI 5
`define NSI_ST_SQ_REDUCED 6
`define NSI_ST_IDLE_EQUAL 7
`define NSI_ST_FACTORY 8
`define NSI_ST_LED_LIT 9
`define NSI_INT_TX 0
`define NSI_INT_COL 1
`define NSI_INT_LINK_LOST 2
`define NSI_INT_LINK_UP 3

// ****************************************************************
// Reset values
// ****************************************************************
`define NSI_CTRL_RST 2'h0
`define NSI_INT_RST 4'h0

`endif

// ===== include/nsi_pkg.sv
// Types of the network status indicator block
package nsi_pkg;

  typedef enum logic [2:0] {
    NSI_LINK_WAIT = 3'h1,
    NSI_LINK_OUT = 3'h2,
    NSI_LINK_IN = 3'h4
  } nsi_link_mode_t;

  typedef enum logic [4:0] {
    NSI_SEL_CTRL = 5'h01,
    NSI_SEL_STATUS = 5'h02,
    NSI_SEL_INT_STATUS = 5'h04,
    NSI_SEL_INT_MASK = 5'h08,
    NSI_SEL_NONE = 5'h10
  } nsi_sel_t;

endpackage

// ===== logic/nsi_sync.sv
// Two flip-flop synchroniser for pin inputs
`timescale 1ns/100ps

module nsi_sync #(
  parameter int W = 5
) (
  input wire logic clk,
  input wire logic [W-1:0] d,
  output logic [W-1:0] q
);

  logic [W-1:0] stage1_r;
  logic [W-1:0] stage2_r;

  // No reset, so straps are seen already during reset
  always_ff @(posedge clk) begin
    stage1_r <= d;
    stage2_r <= stage1_r;
  end

  assign q = stage2_r;

endmodule // nsi_sync

// ===== logic/nsi_stretch.sv
// Retriggerable pulse stretcher
`timescale 1ns/100ps
`include "nsi_regs.svh"

module nsi_stretch #(
  parameter int unsigned CYCLES = `NSI_STRETCH_CYCLES,
  parameter int unsigned CW = $clog2(CYCLES + 1)
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic trigger,
  output logic active
);

  logic [CW-1:0] cnt_r;
  logic active_r;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      cnt_r <= '0;
    end else if (trigger) begin
      cnt_r <= CW'(CYCLES);
    end else if (cnt_r != '0) begin
      cnt_r <= cnt_r - CW'(1);
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      active_r <= 1'b0;
    end else begin
      active_r <= trigger || (cnt_r > CW'(1));
    end
  end

  assign active = active_r;

endmodule // nsi_stretch

// ===== logic/nsi_top.sv
// Network status indicators, link pin, straps and register slave
//
// The register addresses and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/100ps
`include "nsi_regs.svh"

module nsi_top #(
  parameter int unsigned STRETCH_CYCLES = `NSI_STRETCH_CYCLES
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic tx_event,
  input wire logic col_event,
  input wire logic tp_link_ok,
  input wire logic link_good_or_disable_pin_in,
  output logic link_good_or_disable_pin_out,
  output logic link_good_or_disable_pin_oe_n,
  input wire logic interface_path_choice,
  input wire logic squelch_threshold_choice,
  input wire logic idle_level_choice,
  input wire logic factory_check,
  output logic transmit_activity_indicator,
  output logic collision_indicator,
  output logic link_check_enable,
  output logic path_to_aui,
  output logic squelch_reduced,
  output logic aui_idle_equal,
  output logic factory_test_active,
  output logic oscillator_copy,
  output logic irq
);

  // ****************************************************************
  // Declarations
  // ****************************************************************
  logic [4:0] pin_raw;
  logic [4:0] pin_q;
  logic link_pin_q;
  logic path_q;
  logic squelch_q;
  logic idle_q;
  logic factory_q;
  logic tx_active;
  logic col_active;
  nsi_pkg::nsi_link_mode_t mode_r;
  nsi_pkg::nsi_link_mode_t mode_nxt;
  logic link_oe_n_r;
  logic link_out_r;
  logic link_check_r;
  logic path_aui_r;
  logic squelch_r;
  logic idle_r;
  logic factory_r;
  logic tx_ind_r;
  logic col_ind_r;
  logic [3:0] osc_acc_r;
  logic [3:0] osc_sum;
  logic osc_r;
  logic link_prev_r;
  logic link_lost;
  logic link_up;
  logic [3:0] events;
  logic [1:0] ctrl_r;
  logic [3:0] isr_r;
  logic [3:0] isr_nxt;
  logic [3:0] isr_clr;
  logic [3:0] imr_r;
  logic irq_r;
  logic addr_phase;
  logic wr_pend_r;
  nsi_pkg::nsi_sel_t wr_sel_r;
  nsi_pkg::nsi_sel_t rd_sel;
  logic [31:0] rd_word;
  logic [31:0] status_word;
  logic [31:0] hrdata_r;
  logic hreadyout_r;
  logic hresp_r;

  // ****************************************************************
  // Address decode
  // ****************************************************************
  function automatic nsi_pkg::nsi_sel_t nsi_decode(input logic [31:0] a);
    nsi_pkg::nsi_sel_t s;
    s = nsi_pkg::NSI_SEL_NONE;
    if (a == `NSI_OFS_CTRL) begin
      s = nsi_pkg::NSI_SEL_CTRL;
    end else if (a == `NSI_OFS_STATUS) begin
      s = nsi_pkg::NSI_SEL_STATUS;
    end else if (a == `NSI_OFS_INT_STATUS) begin
      s = nsi_pkg::NSI_SEL_INT_STATUS;
    end else if (a == `NSI_OFS_INT_MASK) begin
      s = nsi_pkg::NSI_SEL_INT_MASK;
    end
    return s;
  endfunction

  // ****************************************************************
  // Pin synchronisers
  // ****************************************************************
  assign pin_raw = {factory_check, idle_level_choice,
                    squelch_threshold_choice, interface_path_choice,
                    link_good_or_disable_pin_in};

  nsi_sync #(
    .W(5)
  ) u_sync (
    .clk(clk),
    .d(pin_raw),
    .q(pin_q)
  );

  assign link_pin_q = pin_q[0];
  assign path_q = pin_q[1];
  assign squelch_q = pin_q[2];
  assign idle_q = pin_q[3];
  assign factory_q = pin_q[4];

  // ****************************************************************
  // Activity stretchers
  // ****************************************************************
  // Stretch transmit activity
  nsi_stretch #(
    .CYCLES(STRETCH_CYCLES)
  ) u_tx_stretch (
    .clk(clk),
    .rst_b(rst_b),
    .trigger(tx_event),
    .active(tx_active)
  );

  nsi_stretch #(
    .CYCLES(STRETCH_CYCLES)
  ) u_col_stretch (
    .clk(clk),
    .rst_b(rst_b),
    .trigger(col_event),
    .active(col_active)
  );

  // Lamp test lets software check the activity and collision LEDs without traffic
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      tx_ind_r <= 1'b0;
      col_ind_r <= 1'b0;
    end else begin
      tx_ind_r <= tx_active | ctrl_r[`NSI_CTRL_LAMP_TEST];
      col_ind_r <= col_active | ctrl_r[`NSI_CTRL_LAMP_TEST];
    end
  end

  // ****************************************************************
  // Link pin mode
  // ****************************************************************
  // Decide on first cycle after release
  always_comb begin
    mode_nxt = mode_r;
    unique case (mode_r)
      nsi_pkg::NSI_LINK_WAIT: begin
        mode_nxt = link_pin_q ? nsi_pkg::NSI_LINK_OUT
                              : nsi_pkg::NSI_LINK_IN;
      end
      nsi_pkg::NSI_LINK_OUT: begin
        mode_nxt = nsi_pkg::NSI_LINK_OUT;
      end
      nsi_pkg::NSI_LINK_IN: begin
        mode_nxt = nsi_pkg::NSI_LINK_IN;
      end
      default: begin
        mode_nxt = nsi_pkg::NSI_LINK_WAIT;
      end
    endcase
  end

  // Low level resets at next edge
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      mode_r <= nsi_pkg::NSI_LINK_WAIT;
    end else begin
      mode_r <= mode_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_check_r <= 1'b1;
    end else begin
      link_check_r <= (mode_nxt != nsi_pkg::NSI_LINK_IN);
    end
  end

  // Pin stays released in reset so the strap can be read
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_oe_n_r <= 1'b1;
    end else if (mode_r != nsi_pkg::NSI_LINK_OUT) begin
      link_oe_n_r <= 1'b1;
    end else if (path_aui_r || ctrl_r[`NSI_CTRL_LED_OFF]) begin
      link_oe_n_r <= 1'b1;
    end else begin
      link_oe_n_r <= ~tp_link_ok;
    end
  end

  // Open drain: data is always low, only the enable moves
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_out_r <= 1'b0;
    end else begin
      link_out_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Straps
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      path_aui_r <= 1'b0;
      squelch_r <= 1'b0;
      idle_r <= 1'b0;
      factory_r <= 1'b0;
    end else begin
      path_aui_r <= path_q;
      squelch_r <= squelch_q;
      idle_r <= idle_q;
      factory_r <= factory_q;
    end
  end

  // ****************************************************************
  // Oscillator copy
  // ****************************************************************
  // Clock is not a multiple of 20 MHz: average is exact, edges jitter
  assign osc_sum = osc_acc_r + `NSI_OSC_STEP;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      osc_acc_r <= 4'h0;
      osc_r <= 1'b0;
    end else if (osc_sum >= `NSI_OSC_MOD) begin
      osc_acc_r <= osc_sum - `NSI_OSC_MOD;
      osc_r <= ~osc_r;
    end else begin
      osc_acc_r <= osc_sum;
    end
  end

  // ****************************************************************
  // Events and interrupts
  // ****************************************************************
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      link_prev_r <= 1'b0;
    end else begin
      link_prev_r <= tp_link_ok;
    end
  end

  // Link changes only matter with link checking on and the AUI path off
  assign link_lost = link_prev_r & ~tp_link_ok & link_check_r & ~path_aui_r;
  assign link_up = ~link_prev_r & tp_link_ok & link_check_r & ~path_aui_r;

  always_comb begin
    events = 4'h0;
    events[`NSI_INT_TX] = tx_event;
    events[`NSI_INT_COL] = col_event;
    events[`NSI_INT_LINK_LOST] = link_lost;
    events[`NSI_INT_LINK_UP] = link_up;
  end

  assign isr_clr = (wr_pend_r && wr_sel_r == nsi_pkg::NSI_SEL_INT_STATUS)
                   ? hwdata[3:0] : 4'h0;
  // A new event beats a clear in the same cycle
  assign isr_nxt = (isr_r & ~isr_clr) | events;

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      isr_r <= `NSI_INT_RST;
    end else begin
      isr_r <= isr_nxt;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= |(isr_r & imr_r);
    end
  end

  // ****************************************************************
  // AHB-Lite slave
  // ****************************************************************
  assign addr_phase = hsel & htrans[1] & hready;
  assign rd_sel = nsi_decode(haddr);

  always_comb begin
    status_word = 32'h0;
    status_word[`NSI_ST_TX_IND] = tx_ind_r;
    status_word[`NSI_ST_COL_IND] = col_ind_r;
    status_word[`NSI_ST_LINK_OUT] = (mode_r == nsi_pkg::NSI_LINK_OUT);
    status_word[`NSI_ST_LINK_IN] = (mode_r == nsi_pkg::NSI_LINK_IN);
    status_word[`NSI_ST_LINK_OK] = tp_link_ok;
    status_word[`NSI_ST_PATH_AUI] = path_aui_r;
    status_word[`NSI_ST_SQ_REDUCED] = squelch_r;
    status_word[`NSI_ST_IDLE_EQUAL] = idle_r;
    status_word[`NSI_ST_FACTORY] = factory_r;
    status_word[`NSI_ST_LED_LIT] = ~link_oe_n_r;
  end

  always_comb begin
    rd_word = 32'h0;
    unique case (rd_sel)
      nsi_pkg::NSI_SEL_CTRL: begin
        rd_word = {30'h0, ctrl_r};
      end
      nsi_pkg::NSI_SEL_STATUS: begin
        rd_word = status_word;
      end
      nsi_pkg::NSI_SEL_INT_STATUS: begin
        rd_word = {28'h0, isr_r};
      end
      nsi_pkg::NSI_SEL_INT_MASK: begin
        rd_word = {28'h0, imr_r};
      end
      nsi_pkg::NSI_SEL_NONE: begin
        rd_word = 32'h0;
      end
    endcase
  end

  // Only whole words are used, so hsize is not decoded
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      wr_pend_r <= 1'b0;
      wr_sel_r <= nsi_pkg::NSI_SEL_NONE;
    end else if (addr_phase) begin
      wr_pend_r <= hwrite;
      wr_sel_r <= rd_sel;
    end else if (hready) begin
      wr_pend_r <= 1'b0;
    end
  end

  // Read data is registered at the address edge: zero wait states
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hrdata_r <= 32'h0;
    end else if (addr_phase && !hwrite) begin
      hrdata_r <= rd_word;
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_r <= `NSI_CTRL_RST;
    end else if (wr_pend_r && wr_sel_r == nsi_pkg::NSI_SEL_CTRL) begin
      ctrl_r <= hwdata[1:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      imr_r <= `NSI_INT_RST;
    end else if (wr_pend_r && wr_sel_r == nsi_pkg::NSI_SEL_INT_MASK) begin
      imr_r <= hwdata[3:0];
    end
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end else begin
      hreadyout_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  // ****************************************************************
  // Outputs
  // ****************************************************************
  assign hrdata = hrdata_r;
  assign hreadyout = hreadyout_r;
  assign hresp = hresp_r;
  assign link_good_or_disable_pin_out = link_out_r;
  assign link_good_or_disable_pin_oe_n = link_oe_n_r;
  assign transmit_activity_indicator = tx_ind_r;
  assign collision_indicator = col_ind_r;
  assign link_check_enable = link_check_r;
  assign path_to_aui = path_aui_r;
  assign squelch_reduced = squelch_r;
  assign aui_idle_equal = idle_r;
  assign factory_test_active = factory_r;
  assign oscillator_copy = osc_r;
  assign irq = irq_r;

endmodule // nsi_top

// ===== bench/nsi_monitor.sv
// Concurrent checks on the ports of the network status indicator top
`timescale 1ns/100ps
`include "nsi_regs.svh"

module nsi_monitor #(
  parameter int unsigned STRETCH_CYCLES = 16
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic hresp,
  input wire logic hreadyout,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic tx_event,
  input wire logic col_event,
  input wire logic tp_link_ok,
  input wire logic link_good_or_disable_pin_out,
  input wire logic link_good_or_disable_pin_oe_n,
  input wire logic interface_path_choice,
  input wire logic squelch_threshold_choice,
  input wire logic transmit_activity_indicator,
  input wire logic collision_indicator,
  input wire logic link_check_enable,
  input wire logic path_to_aui,
  input wire logic squelch_reduced,
  input wire logic oscillator_copy,
  input wire logic irq
);
  int unsigned cnt_r [2];
  logic ctrl_wr_r;
  logic lamp_r;
  // Lamp test forces both indicators, so follow the control word
  always_ff @(posedge clk) begin
    if (!rst_b) begin
      ctrl_wr_r <= 1'b0;
      lamp_r <= 1'b0;
    end else begin
      ctrl_wr_r <= hsel && htrans[1] && hreadyout && hwrite &&
                   haddr == `NSI_OFS_CTRL;
      if (ctrl_wr_r) begin
        lamp_r <= hwdata[`NSI_CTRL_LAMP_TEST];
      end
    end
  end
  // ****************************************************************
  // Cycles since last event, saturating past the stretch end
  // ****************************************************************
  always_ff @(posedge clk) begin
    for (int i = 0; i < 2; i++) begin
      if (!rst_b) begin
        cnt_r[i] <= 0;
      end else if ((i == 0) ? tx_event : col_event) begin
        cnt_r[i] <= 1;
      end else if (cnt_r[i] != 0 && cnt_r[i] < STRETCH_CYCLES + 2) begin
        cnt_r[i] <= cnt_r[i] + 1;
      end
    end
  end
  // ****************************************************************
  // Assertions
  // ****************************************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // Strap held long enough to cross the synchroniser
  sequence held_s(logic p);
    $stable(p) [*4];
  endsequence
  // Indicator shows two edges after the event pulse
  AST_TX_STRETCH: assert property (cnt_r[0] > 1 &&
    cnt_r[0] <= STRETCH_CYCLES + 1 |-> transmit_activity_indicator)
    else $error("transmit indicator dropped early");
  AST_TX_ENDS: assert property (cnt_r[0] >= STRETCH_CYCLES + 2
    && !lamp_r && !$past(lamp_r) |-> !transmit_activity_indicator)
    else $error("transmit stuck");
  AST_COL_STRETCH: assert property (cnt_r[1] > 1 &&
    cnt_r[1] <= STRETCH_CYCLES + 1 |-> collision_indicator)
    else $error("collision indicator dropped early");
  AST_COL_ENDS: assert property (cnt_r[1] >= STRETCH_CYCLES + 2
    && !lamp_r && !$past(lamp_r) |-> !collision_indicator)
    else $error("collision stuck");
  AST_LAMP: assert property (lamp_r |=> transmit_activity_indicator &&
    collision_indicator) else $error("lamp test not shown");
  AST_OPEN_DRAIN: assert property (!link_good_or_disable_pin_out)
    else $error("link pin driven high");
  AST_LED_CAUSE: assert property (!link_good_or_disable_pin_oe_n
    |-> $past(tp_link_ok) && link_check_enable)
    else $error("link pin pulled without good link");
  AST_INPUT_MODE: assert property (!link_check_enable
    |-> link_good_or_disable_pin_oe_n) else $error("input pin driven");
  AST_AUI_RELEASE: assert property (path_to_aui && $past(path_to_aui)
    |-> link_good_or_disable_pin_oe_n) else $error("pin driven in aui");
  AST_SQUELCH: assert property (held_s(squelch_threshold_choice)
    |-> squelch_reduced == squelch_threshold_choice)
    else $error("squelch strap not followed");
  AST_PATH: assert property (held_s(interface_path_choice)
    |-> path_to_aui == interface_path_choice)
    else $error("path strap not followed");
  AST_OSC: assert property ($past(rst_b, 3) && $stable(oscillator_copy)
    |=> $changed(oscillator_copy)) else $error("oscillator copy stalled");
  AST_BUS_OKAY: assert property (hreadyout && !hresp)
    else $error("bus not ready or error");
  AST_RESET: assert property (disable iff (1'b0) !rst_b |=>
    !transmit_activity_indicator && !collision_indicator && !irq &&
    link_good_or_disable_pin_oe_n) else $error("reset not applied");
endmodule // nsi_monitor

bind nsi_top nsi_monitor #(.STRETCH_CYCLES(STRETCH_CYCLES)) i_mon (.clk,
  .rst_b, .hresp, .hreadyout, .hsel, .haddr, .htrans, .hwrite, .hwdata,
  .tx_event, .col_event, .tp_link_ok,
  .link_good_or_disable_pin_out, .link_good_or_disable_pin_oe_n,
  .interface_path_choice, .squelch_threshold_choice,
  .transmit_activity_indicator, .collision_indicator, .link_check_enable,
  .path_to_aui, .squelch_reduced, .oscillator_copy, .irq);

// ===== bench/nsi_partner.sv
// Board and transceiver model at the network side of the block
`timescale 1ns/100ps

module nsi_partner (
  input wire logic oe_n,
  input wire logic pin_out,
  input wire logic strap_low,
  input wire logic link_up,
  input wire logic factory_req,
  output logic pin_level,
  output logic tp_link_ok,
  output logic factory_check
);
  // board strap low
  // Pull-up wins only when neither the strap nor the driver pulls low
  assign pin_level = (strap_low || (!oe_n && !pin_out)) ? 1'b0 : 1'b1;
  assign tp_link_ok = link_up;
  assign factory_check = factory_req;
endmodule // nsi_partner

// ===== bench/test_network_status_indicators.sv
// Self-checking bench for the network status indicator block
`timescale 1ns/100ps
`include "nsi_regs.svh"

module test_network_status_indicators;
  localparam int unsigned S = 16;
  logic clk = 0, rst_b = 0, hsel = 0, hwrite = 0, tx_event = 0;
  logic col_event = 0, interface_path_choice = 0, idle_level_choice = 0;
  logic squelch_threshold_choice = 0, strap_low = 0, link_up = 0;
  logic factory_req = 0;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  logic hreadyout, hresp, tp_link_ok, factory_check, irq;
  logic link_good_or_disable_pin_in, link_good_or_disable_pin_out;
  logic link_good_or_disable_pin_oe_n, transmit_activity_indicator;
  logic collision_indicator, link_check_enable, path_to_aui;
  logic squelch_reduced, aui_idle_equal, factory_test_active;
  logic oscillator_copy, prev;
  logic [1:0] ind;
  int num_errors = 0, checked = 0, cycles = 0, n;
  assign ind = {collision_indicator, transmit_activity_indicator};

  nsi_top #(.STRETCH_CYCLES(S)) i_dut (.clk, .rst_b, .hsel, .haddr,
    .htrans, .hwrite, .hsize, .hwdata, .hready(hreadyout), .hrdata,
    .hreadyout, .hresp, .tx_event, .col_event, .tp_link_ok,
    .link_good_or_disable_pin_in, .link_good_or_disable_pin_out,
    .link_good_or_disable_pin_oe_n, .interface_path_choice,
    .squelch_threshold_choice, .idle_level_choice, .factory_check,
    .transmit_activity_indicator, .collision_indicator, .link_check_enable,
    .path_to_aui, .squelch_reduced, .aui_idle_equal, .factory_test_active,
    .oscillator_copy, .irq);
  nsi_partner i_far (.oe_n(link_good_or_disable_pin_oe_n),
    .pin_out(link_good_or_disable_pin_out), .strap_low(strap_low),
    .link_up(link_up), .factory_req(factory_req),
    .pin_level(link_good_or_disable_pin_in), .tp_link_ok(tp_link_ok),
    .factory_check(factory_check));

  // ****************************************************************
  // Clock, timeout and closing report
  // ****************************************************************
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cycles++;
    if (cycles == 4000) begin
      num_errors++;
      end_sim();
    end
  end
  task automatic end_sim();
    $display("errors %0d, comparisons %0d", num_errors, checked);
    if (num_errors == 0 && checked > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask
  // ****************************************************************
  // Stimulus tasks
  // ****************************************************************
  task automatic cyc(input int k);
    repeat (k) @(posedge clk);
  endtask
  task automatic do_reset(input logic s);
    rst_b <= 1'b0;
    strap_low <= s;
    cyc(4);
    rst_b <= 1'b1;
    cyc(1);
  endtask
  // Read data is taken at the edge closing the data phase
  task automatic ahb(input logic w, input logic [31:0] a,
      input logic [31:0] d, output logic [31:0] q);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hreadyout !== 1'b1);
    q = hrdata;
  endtask
  task automatic ev(input int w);
    if (w == 0) tx_event <= 1'b1;
    else col_event <= 1'b1;
    cyc(1);
    tx_event <= 1'b0;
    col_event <= 1'b0;
  endtask
  // ****************************************************************
  // Tests
  // ****************************************************************
  initial begin
    do_reset(1'b0);
    cyc(3);
    chk(link_check_enable, 1);
    link_up <= 1'b1;
    cyc(3);
    chk(link_good_or_disable_pin_oe_n, 0);
    chk(link_good_or_disable_pin_in, 0);
    link_up <= 1'b0;
    cyc(3);
    chk(link_good_or_disable_pin_oe_n, 1);
    link_up <= 1'b1;
    interface_path_choice <= 1'b1;
    cyc(5);
    chk(path_to_aui, 1);
    chk(link_good_or_disable_pin_oe_n, 1);
    interface_path_choice <= 1'b0;
    cyc(5);
    chk(path_to_aui, 0);
    for (int v = 1; v >= 0; v--) begin
      squelch_threshold_choice <= v[0];
      idle_level_choice <= v[0];
      factory_req <= v[0];
      cyc(5);
      chk(squelch_reduced, v);
      chk(aui_idle_equal, v);
      chk(factory_test_active, v);
    end
    // A retrigger must push the end out past the first event's stretch
    for (int w = 0; w < 2; w++) begin
      ev(w);
      cyc(2);
      chk(ind[w], 1);
      cyc(8);
      ev(w);
      cyc(14);
      chk(ind[w], 1);
      cyc(6);
      chk(ind[w], 0);
    end
    n = 0;
    prev = oscillator_copy;
    repeat (50) begin
      cyc(1);
      if (oscillator_copy !== prev) n++;
      prev = oscillator_copy;
    end
    chk(n, 40);
    ahb(1, `NSI_OFS_CTRL, 32'h2, rd);
    ahb(0, `NSI_OFS_CTRL, 32'h0, rd);
    chk(rd, 32'h2);
    chk(link_good_or_disable_pin_oe_n, 1);
    ahb(1, `NSI_OFS_CTRL, 32'h3, rd);
    cyc(2);
    chk(ind, 32'h3);
    ahb(1, `NSI_OFS_CTRL, 32'h0, rd);
    cyc(2);
    chk(link_good_or_disable_pin_oe_n, 0);
    chk(ind, 32'h0);
    ahb(1, 32'h10, 32'hffffffff, rd);
    ahb(0, 32'h10, 32'h0, rd);
    chk(rd, 32'h0);
    ahb(0, `NSI_OFS_INT_STATUS, 32'h0, rd);
    chk(rd, 32'hf);
    ahb(1, `NSI_OFS_INT_STATUS, 32'hf, rd);
    ahb(1, `NSI_OFS_INT_MASK, 32'h1, rd);
    ev(0);
    cyc(3);
    chk(irq, 1);
    ahb(0, `NSI_OFS_INT_STATUS, 32'h0, rd);
    chk(rd, 32'h1);
    ahb(1, `NSI_OFS_INT_MASK, 32'h0, rd);
    cyc(2);
    chk(irq, 0);
    ahb(1, `NSI_OFS_INT_STATUS, 32'h1, rd);
    link_up <= 1'b0;
    cyc(4);
    ahb(0, `NSI_OFS_INT_STATUS, 32'h0, rd);
    chk(rd, 32'h4);
    ahb(0, `NSI_OFS_STATUS, 32'h0, rd);
    chk(rd & 32'h20c, 32'h4);
    do_reset(1'b1);
    link_up <= 1'b1;
    cyc(4);
    chk(link_check_enable, 0);
    chk(link_good_or_disable_pin_oe_n, 1);
    ahb(0, `NSI_OFS_STATUS, 32'h0, rd);
    chk(rd & 32'h20c, 32'h8);
    end_sim();
  end
endmodule // test_network_status_indicators
